// ==== rtl/touch_irq_calibration.sv ====
// Purpose: Alert line generation, baseline calibration, stuck keys, thresholds
// Assumes: Register port capture runs on link_clk; register file and the rest on clk
// Notes:   Alert pin is open drain: output tied low, enable drives it
//
// Functional notes
// - Buffered-data alert raised only when buffer-empty flag falls from one to zero.
// - FIFO access withdraws buffered alert; rearm only after buffer becomes empty again.
// - Fault alert raised when fault code goes from zero to non-zero.
// - Fault alert withdrawn only by fault_clear in a stop mode, or by alert enable going low.
// - Alert enable low: all conditions ignored, alert line never latches.
// - Least alert spacing is master tick period times rate factor times four ms.
// - Low-power run spacing: ((low_power_run setting+5)/8+1)*8*rate*4 ms.
// - Events inside spacing wait until it expires; otherwise latch at once.
// - Alert line pulled low and held until host clears source; open drain.
// - After reset the first sample is stored as every electrode's baseline.
// - Touch found from difference between baseline and current measurement.
// - Run-time auto-calibration happens only while auto-calibration enable is high.
// - Baseline recomputed once per 64 acquisition samples.
// - Auto-calibration falling due during any touch is skipped.
// - Touch lasting beyond stuck timeout is absorbed into baseline and dropped.
// - Stuck timeout code zero disables stuck-key absorption entirely.
// - Stuck timeout register at 0x12 is read-write; code n gives factor n+1.
// - Threshold registers 0x04 to 0x0B read-write; code n is level n+1.
// - Out-of-range threshold writes are forced to code 0x3F.
// - Buffer-empty flag high means buffer empty, low means data present.
// - Fault code 00 none, 01 short to ground, 10 short to supply.
// - Fault clear writes act only in a stop mode; ignored during run modes.

`timescale 1ns/1ps

module touch_irq_calibration
  import touch_irq_calibration_pkg::*;
#(
  parameter int MS_COUNT = MS_CYCLES
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    link_clk,
  input  wire config_type              cfg,
  input  wire logic                    buffer_empty_flag,
  input  wire logic [1:0]              fault_code,
  input  wire logic                    fifo_access,
  input  wire logic                    fault_clear,
  input  wire sample_type              sample,
  input  wire reg_req_type             reg_req,
  output logic                         reg_busy,
  output logic                         reg_done,
  output logic [7:0]                   reg_rdata,
  output logic                         alert_out,
  output logic                         alert_oe,
  output logic [ELECTRODES-1:0]        touch_status
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [7:0] clamp_threshold(input logic [7:0] value);
    if (value > THRESHOLD_MAX) begin
      return THRESHOLD_MAX;
    end
    return value;
  endfunction

  function automatic logic is_threshold_addr(input logic [7:0] addr);
    return (addr >= THRESHOLD_FIRST_OFFSET) && (addr <= THRESHOLD_LAST_OFFSET);
  endfunction

  function automatic logic [HOLDOFF_W-1:0] holdoff_ms(input config_type c);
    logic [HOLDOFF_W-1:0] base;
    base = '0;
    if (c.low_power_run) begin
      base = HOLDOFF_W'((({2'h0, c.low_power_run_tick_setting} + 10'(LOW_POWER_RUN_OFFSET)) / 10'(LOW_POWER_RUN_STEP)
             + 10'h001) * 10'(LOW_POWER_RUN_STEP));
    end else begin
      base = HOLDOFF_W'(c.master_tick_period);
    end
    return HOLDOFF_W'(base * HOLDOFF_W'(c.alert_rate_factor) * HOLDOFF_W'(HOLDOFF_MULT));
  endfunction

  function automatic logic touch_detect(input logic [MEAS_W-1:0] meas,
                                        input logic [MEAS_W-1:0] base,
                                        input logic [7:0]        code);
    logic [MEAS_W-1:0] diff;
    diff = meas - base;
    return (meas > base) && (diff >= MEAS_W'({1'b0, code} + 9'h001));
  endfunction

  // ----------------------------------------------------------------
  // Link domain: request capture and completion
  // ----------------------------------------------------------------
  logic        lk_req_tgl_reg;
  logic        lk_busy_reg;
  logic        lk_write_reg;
  logic [7:0]  lk_addr_reg;
  logic [7:0]  lk_wdata_reg;
  logic        lk_ack_s1_reg;
  logic        lk_ack_s2_reg;
  logic        lk_ack_seen_reg;
  logic        core_ack_tgl_reg;
  logic [7:0]  core_rdata_reg;

  assign reg_busy = lk_busy_reg;

  // Ack toggle into link domain
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      lk_ack_s1_reg <= 1'b0;
      lk_ack_s2_reg <= 1'b0;
    end else begin
      lk_ack_s1_reg <= core_ack_tgl_reg;
      lk_ack_s2_reg <= lk_ack_s1_reg;
    end
  end

  // Take request, finish on returned ack
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      lk_req_tgl_reg  <= 1'b0;
      lk_busy_reg     <= 1'b0;
      lk_write_reg    <= 1'b0;
      lk_addr_reg     <= 8'h00;
      lk_wdata_reg    <= 8'h00;
      lk_ack_seen_reg <= 1'b0;
      reg_rdata       <= 8'h00;
      reg_done        <= 1'b0;
    end else begin
      reg_done <= 1'b0;
      if (reg_req.req && !lk_busy_reg) begin
        lk_req_tgl_reg <= ~lk_req_tgl_reg;
        lk_busy_reg    <= 1'b1;
        lk_write_reg   <= reg_req.write;
        lk_addr_reg    <= reg_req.addr;
        lk_wdata_reg   <= reg_req.wdata;
      end else if (lk_busy_reg && (lk_ack_s2_reg != lk_ack_seen_reg)) begin
        lk_ack_seen_reg <= lk_ack_s2_reg;
        lk_busy_reg     <= 1'b0;
        reg_rdata       <= core_rdata_reg;
        reg_done        <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Core domain: register file
  // ----------------------------------------------------------------
  logic                         core_req_s1_reg;
  logic                         core_req_s2_reg;
  logic                         core_req_seen_reg;
  logic [ELECTRODES-1:0][7:0]   threshold_level_reg;
  logic [7:0]                   stuck_timeout_factor_reg;
  logic                         core_op;
  logic [7:0]                   thr_index;

  assign core_op   = core_req_s2_reg != core_req_seen_reg;
  assign thr_index = lk_addr_reg - THRESHOLD_FIRST_OFFSET;

  // Request toggle into core domain
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_req_s1_reg <= 1'b0;
      core_req_s2_reg <= 1'b0;
    end else begin
      core_req_s1_reg <= lk_req_tgl_reg;
      core_req_s2_reg <= core_req_s1_reg;
    end
  end

  // One register access per request toggle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_req_seen_reg        <= 1'b0;
      core_ack_tgl_reg         <= 1'b0;
      core_rdata_reg           <= 8'h00;
      threshold_level_reg      <= {ELECTRODES{THRESHOLD_RESET}};
      stuck_timeout_factor_reg <= STUCK_TIMEOUT_RESET;
    end else if (core_op) begin
      core_req_seen_reg <= core_req_s2_reg;
      core_ack_tgl_reg  <= ~core_ack_tgl_reg;
      core_rdata_reg    <= UNMAPPED_READ;
      if (is_threshold_addr(lk_addr_reg)) begin
        if (lk_write_reg) begin
          threshold_level_reg[thr_index[2:0]] <= clamp_threshold(lk_wdata_reg);
        end else begin
          core_rdata_reg <= threshold_level_reg[thr_index[2:0]];
        end
      end else if (lk_addr_reg == STUCK_TIMEOUT_OFFSET) begin
        if (lk_write_reg) begin
          stuck_timeout_factor_reg <= lk_wdata_reg;
        end else begin
          core_rdata_reg <= stuck_timeout_factor_reg;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Alert sources
  // ----------------------------------------------------------------
  logic        empty_prev_reg;
  logic        buf_armed_reg;
  logic [1:0]  fault_prev_reg;
  logic        buf_event;
  logic        fault_event;
  logic        pend_buf_reg;
  logic        pend_fault_reg;
  logic        buf_src_reg;
  logic        fault_src_reg;
  logic        may_latch;
  logic        fault_clear_ok;

  assign buf_event      = empty_prev_reg && !buffer_empty_flag && buf_armed_reg;
  assign fault_event    = (fault_prev_reg == FAULT_NONE) && (fault_code != FAULT_NONE);
  assign fault_clear_ok = fault_clear && cfg.stop_mode;

  // Edge history and buffer rearm
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      empty_prev_reg <= 1'b1;
      fault_prev_reg <= FAULT_NONE;
      buf_armed_reg  <= 1'b1;
    end else begin
      empty_prev_reg <= buffer_empty_flag;
      fault_prev_reg <= fault_code;
      if (buffer_empty_flag) begin
        buf_armed_reg <= 1'b1;
      end else if (buf_event) begin
        buf_armed_reg <= 1'b0;
      end
    end
  end

  // Pending events waiting out the hold-off
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_buf_reg   <= 1'b0;
      pend_fault_reg <= 1'b0;
    end else if (!cfg.alert_enable) begin
      pend_buf_reg   <= 1'b0;
      pend_fault_reg <= 1'b0;
    end else begin
      pend_buf_reg   <= (pend_buf_reg || buf_event) && !may_latch;
      pend_fault_reg <= (pend_fault_reg || fault_event) && !may_latch;
    end
  end

  // Latched sources; a latch wins over a same-cycle clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      buf_src_reg   <= 1'b0;
      fault_src_reg <= 1'b0;
    end else begin
      if (may_latch && (pend_buf_reg || buf_event)) begin
        buf_src_reg <= 1'b1;
      end else if (fifo_access || !cfg.alert_enable) begin
        buf_src_reg <= 1'b0;
      end
      if (may_latch && (pend_fault_reg || fault_event)) begin
        fault_src_reg <= 1'b1;
      end else if (fault_clear_ok || !cfg.alert_enable) begin
        fault_src_reg <= 1'b0;
      end
    end
  end

  assign alert_out = 1'b0;
  assign alert_oe  = buf_src_reg || fault_src_reg;

  // ----------------------------------------------------------------
  // Hold-off timer
  // ----------------------------------------------------------------
  logic [$clog2(MS_COUNT+1)-1:0] ms_cnt_reg;
  logic                          ms_tick;
  logic [HOLDOFF_W-1:0]          holdoff_reg;
  logic                          latching;

  assign ms_tick   = ms_cnt_reg == ($clog2(MS_COUNT+1))'(MS_COUNT - 1);
  assign may_latch = cfg.alert_enable && (holdoff_reg == '0);
  assign latching  = may_latch && (pend_buf_reg || buf_event || pend_fault_reg || fault_event);

  // Millisecond prescaler, restarted on latch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ms_cnt_reg <= '0;
    end else if (latching) begin
      ms_cnt_reg <= '0;
    end else if (ms_tick) begin
      ms_cnt_reg <= '0;
    end else begin
      ms_cnt_reg <= ms_cnt_reg + 1'b1;
    end
  end

  // Hold-off count in milliseconds
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      holdoff_reg <= '0;
    end else if (latching) begin
      holdoff_reg <= holdoff_ms(cfg);
    end else if (ms_tick && holdoff_reg != '0) begin
      holdoff_reg <= holdoff_reg - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Calibration and touch detection
  // ----------------------------------------------------------------
  cal_state_type                          cal_state_reg;
  logic [ELECTRODES-1:0][MEAS_W-1:0]      baseline_reg;
  logic [ELECTRODES-1:0][STUCK_W-1:0]     stuck_cnt_reg;
  logic [5:0]                             cal_cnt_reg;
  logic [ELECTRODES-1:0]                  raw_touch;
  logic [STUCK_W-1:0]                     stuck_limit;
  logic                                   cal_due;

  assign stuck_limit = STUCK_W'(({1'b0, stuck_timeout_factor_reg} + 9'h001)
                       * STUCK_W'(CAL_SAMPLES));
  assign cal_due     = cal_cnt_reg == 6'(CAL_SAMPLES - 1);

  // Per-electrode touch compare
  always_comb begin
    for (int i = 0; i < ELECTRODES; i++) begin
      raw_touch[i] = touch_detect(sample.meas[i], baseline_reg[i], threshold_level_reg[i]);
    end
  end

  // Initial sample, then auto-calibration count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cal_state_reg <= CAL_INITIAL;
      cal_cnt_reg   <= '0;
    end else if (sample.valid) begin
      unique case (cal_state_reg)
        CAL_INITIAL: cal_state_reg <= CAL_RUNNING;
        CAL_RUNNING: cal_cnt_reg   <= cal_cnt_reg + 1'b1;
      endcase
    end
  end

  // Baseline, stuck counters and status
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      baseline_reg  <= '0;
      stuck_cnt_reg <= '0;
      touch_status  <= '0;
    end else if (sample.valid) begin
      if (cal_state_reg == CAL_INITIAL) begin
        baseline_reg <= sample.meas;
      end else if (cal_due && cfg.auto_calib_enable && raw_touch == '0) begin
        baseline_reg <= sample.meas;
        stuck_cnt_reg <= '0;
        touch_status  <= '0;
      end else begin
        for (int i = 0; i < ELECTRODES; i++) begin
          if (!raw_touch[i]) begin
            stuck_cnt_reg[i] <= '0;
            touch_status[i]  <= 1'b0;
          end else if (stuck_timeout_factor_reg != STUCK_TIMEOUT_RESET
                       && stuck_cnt_reg[i] >= stuck_limit - 1'b1) begin
            baseline_reg[i]  <= sample.meas[i];
            stuck_cnt_reg[i] <= '0;
            touch_status[i]  <= 1'b0;
          end else begin
            if (stuck_timeout_factor_reg != STUCK_TIMEOUT_RESET) begin
              stuck_cnt_reg[i] <= stuck_cnt_reg[i] + 1'b1;
            end
            touch_status[i] <= 1'b1;
          end
        end
      end
    end
  end

endmodule

// ==== rtl/touch_irq_calibration_pkg.sv ====
// Purpose: Shared constants and types for the touch alert and calibration block
// Assumes: 20 MHz core clock, 8 electrodes, 8-bit register port
// Notes:   Offsets are register addresses on the serial register port

package touch_irq_calibration_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int ELECTRODES      = 8;
  localparam int MEAS_W          = 16;
  localparam int HOLDOFF_W       = 20;
  localparam int STUCK_W         = 15;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] THRESHOLD_FIRST_OFFSET = 8'h04;
  localparam logic [7:0] THRESHOLD_LAST_OFFSET  = 8'h0B;
  localparam logic [7:0] STUCK_TIMEOUT_OFFSET   = 8'h12;
  localparam logic [7:0] THRESHOLD_RESET        = 8'h3F;
  localparam logic [7:0] THRESHOLD_MAX          = 8'h3F;
  localparam logic [7:0] STUCK_TIMEOUT_RESET    = 8'h00;
  localparam logic [7:0] UNMAPPED_READ          = 8'h00;

  // ----------------------------------------------------------------
  // Fault codes and timing
  // ----------------------------------------------------------------
  localparam logic [1:0] FAULT_NONE         = 2'h0;
  localparam logic [1:0] FAULT_SHORT_GROUND = 2'h1;
  localparam logic [1:0] FAULT_SHORT_SUPPLY = 2'h2;
  localparam int         CLK_PERIOD_NS      = 50;
  localparam int         MS_NS              = 1000000;
  localparam int         MS_CYCLES          = MS_NS / CLK_PERIOD_NS;
  localparam int         HOLDOFF_MULT       = 4;
  localparam int         LOW_POWER_RUN_OFFSET        = 5;
  localparam int         LOW_POWER_RUN_STEP          = 8;
  localparam int         CAL_SAMPLES        = 64;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic {CAL_INITIAL, CAL_RUNNING} cal_state_type;

  typedef struct packed {
    logic       alert_enable;
    logic [7:0] alert_rate_factor;
    logic [7:0] master_tick_period;
    logic [7:0] low_power_run_tick_setting;
    logic       low_power_run;
    logic       stop_mode;
    logic       auto_calib_enable;
  } config_type;

  typedef struct packed {
    logic                                 valid;
    logic [ELECTRODES-1:0][MEAS_W-1:0]    meas;
  } sample_type;

  typedef struct packed {
    logic       req;
    logic       write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

endpackage

// ==== testbench/touch_irq_calibration_sva.sv ====
// Purpose: Assertions on alert, calibration and register port outputs
// Assumes: MS_COUNT equals the value given to the design instance
// Notes:   Bound to the top module at the foot of this file
`timescale 1ns/1ps
module touch_irq_calibration_sva
  import touch_irq_calibration_pkg::*;
#(
  parameter int MS_COUNT = MS_CYCLES
) (
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  link_clk,
  input wire config_type            cfg,
  input wire logic                  buffer_empty_flag,
  input wire logic [1:0]            fault_code,
  input wire logic                  fifo_access,
  input wire logic                  fault_clear,
  input wire sample_type            sample,
  input wire reg_req_type           reg_req,
  input wire logic                  reg_busy,
  input wire logic                  reg_done,
  input wire logic [7:0]            reg_rdata,
  input wire logic                  alert_out,
  input wire logic                  alert_oe,
  input wire logic [ELECTRODES-1:0] touch_status
);
  // ----------------------------------------------------------------
  // Cycles since last alert rise
  // ----------------------------------------------------------------
  int   gap_reg;
  logic oe_reg;
  int   hold_cyc;
  assign hold_cyc = cfg.low_power_run ?
    ((int'(cfg.low_power_run_tick_setting) + LOW_POWER_RUN_OFFSET) / LOW_POWER_RUN_STEP + 1) * LOW_POWER_RUN_STEP
      * int'(cfg.alert_rate_factor) * HOLDOFF_MULT * MS_COUNT :
    int'(cfg.master_tick_period) * int'(cfg.alert_rate_factor) * HOLDOFF_MULT * MS_COUNT;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gap_reg <= 1000000;
      oe_reg  <= 1'b0;
    end else begin
      oe_reg <= alert_oe;
      if (alert_oe && !oe_reg)
        gap_reg <= 1;
      else if (gap_reg < 1000000)
        gap_reg <= gap_reg + 1;
    end
  end
  sequence accept_s;
    reg_req.req && !reg_busy;
  endsequence
  sequence finish_s;
    ##[2:60] reg_done;
  endsequence
  open_drain_a: assert property (@(posedge clk) disable iff (rst) alert_out == 1'b0)
    else $error("alert data not low");
  disabled_quiet_a: assert property (@(posedge clk) disable iff (rst)
    !cfg.alert_enable ##1 !cfg.alert_enable |-> !alert_oe)
    else $error("alert while disabled");
  latch_hold_a: assert property (@(posedge clk) disable iff (rst)
    alert_oe && cfg.alert_enable && !fifo_access && !(fault_clear && cfg.stop_mode)
      |=> alert_oe)
    else $error("alert released without clear");
  spacing_a: assert property (@(posedge clk) disable iff (rst)
    alert_oe && !oe_reg |-> gap_reg >= hold_cyc)
    else $error("alert spacing too short");
  immediate_latch_a: assert property (@(posedge clk) disable iff (rst)
    cfg.alert_enable && !alert_oe && $past(buffer_empty_flag) && !buffer_empty_flag
      && gap_reg > hold_cyc + 2 |-> ##[1:2] alert_oe)
    else $error("buffer alert not latched");
  fault_latch_a: assert property (@(posedge clk) disable iff (rst)
    cfg.alert_enable && !alert_oe && $past(fault_code) == FAULT_NONE
      && fault_code != FAULT_NONE && gap_reg > hold_cyc + 2 |-> ##[1:2] alert_oe)
    else $error("fault alert not latched");
  status_stable_a: assert property (@(posedge clk) disable iff (rst)
    !sample.valid |=> $stable(touch_status))
    else $error("status moved without sample");
  done_bound_a: assert property (@(posedge link_clk) disable iff (rst)
    accept_s |-> finish_s)
    else $error("register access not completed");
  busy_hold_a: assert property (@(posedge link_clk) disable iff (rst)
    accept_s |=> reg_busy)
    else $error("accepted access not busy");
  done_pulse_a: assert property (@(posedge link_clk) disable iff (rst)
    reg_done |-> !reg_busy ##1 !reg_done)
    else $error("done pulse malformed");
endmodule

bind touch_irq_calibration touch_irq_calibration_sva #(.MS_COUNT(MS_COUNT)) chk_inst (
  .clk(clk), .rst(rst), .link_clk(link_clk), .cfg(cfg),
  .buffer_empty_flag(buffer_empty_flag), .fault_code(fault_code),
  .fifo_access(fifo_access), .fault_clear(fault_clear), .sample(sample),
  .reg_req(reg_req), .reg_busy(reg_busy), .reg_done(reg_done), .reg_rdata(reg_rdata),
  .alert_out(alert_out), .alert_oe(alert_oe), .touch_status(touch_status)
);

// ==== testbench/touch_host_model.sv ====
// Purpose: Host side of the register port
// Assumes: One access outstanding at a time
// Notes:   Request released after the taking edge
`timescale 1ns/1ps
module touch_host_model
  import touch_irq_calibration_pkg::*;
(
  input  wire logic       link_clk,
  input  wire logic       reg_busy,
  input  wire logic       reg_done,
  input  wire logic [7:0] reg_rdata,
  output reg_req_type     reg_req
);
  logic [7:0] rdata;
  logic       timed_out;
  initial begin
    reg_req   = '{1'b0, 1'b0, 8'h5A, 8'hA5};
    timed_out = 1'b0;
  end
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] wd);
    int n;
    @(posedge link_clk);
    reg_req <= '{1'b1, w, a, wd};
    @(posedge link_clk);
    reg_req <= '{1'b0, ~w, ~a, ~wd};
    n = 0;
    do begin
      @(posedge link_clk);
      n++;
    end while (reg_done !== 1'b1 && n < 200);
    timed_out = (reg_done !== 1'b1);
    rdata     = reg_rdata;
  endtask
endmodule

// ==== testbench/touch_irq_calibration_tb_top.sv ====
// Purpose: Self-checking bench for the alert and calibration block
// Assumes: MS_COUNT of 4, tick period and rate factor of one
// Notes:   Inputs change by non-blocking assignment at rising clk
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module touch_irq_calibration_tb_top
  import touch_irq_calibration_pkg::*;
;
  localparam int          MS      = 4;
  localparam int          HOLD    = 1 * 1 * 4 * MS;
  localparam int          HOLD_LP = ((3 + 5) / 8 + 1) * 8 * 1 * 4 * MS;
  localparam logic [15:0] BASE    = 16'h1000;
  logic clk, rst, link_clk, buffer_empty_flag, fifo_access, fault_clear;
  logic reg_busy, reg_done, alert_out, alert_oe;
  logic [1:0] fault_code;
  logic [7:0] reg_rdata;
  logic [ELECTRODES-1:0] touch_status;
  config_type cfg;
  sample_type sample;
  reg_req_type reg_req;
  int n_fail, n_tests, cyc;
  wire alert_pin_n = alert_oe ? alert_out : 1'b1;
  touch_irq_calibration #(.MS_COUNT(MS)) uut (
    .clk(clk), .rst(rst), .link_clk(link_clk), .cfg(cfg),
    .buffer_empty_flag(buffer_empty_flag), .fault_code(fault_code),
    .fifo_access(fifo_access), .fault_clear(fault_clear), .sample(sample),
    .reg_req(reg_req), .reg_busy(reg_busy), .reg_done(reg_done), .reg_rdata(reg_rdata),
    .alert_out(alert_out), .alert_oe(alert_oe), .touch_status(touch_status));
  touch_host_model host (.link_clk(link_clk), .reg_busy(reg_busy), .reg_done(reg_done),
    .reg_rdata(reg_rdata), .reg_req(reg_req));
  // ----------------------------------------------------------------
  // Clocks and helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #3 link_clk = ~link_clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  task automatic finish_test();
    $display("tests=%0d fails=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] wd);
    host.access(w, a, wd);
    tick(1);
    if (host.timed_out) begin
      n_fail++;
      finish_test();
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    `CHK(host.rdata, e)
  endtask
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] wd, input logic [7:0] e);
    acc(1'b1, a, wd);
    rd_chk(a, e);
  endtask
  task automatic wait_alert(input int lim);
    int n;
    n = 0;
    while (alert_oe !== 1'b1 && n < lim) begin
      tick(1);
      n++;
    end
    `CHK(alert_pin_n, 1'b0)
    if (alert_oe !== 1'b1) finish_test();
  endtask
  task automatic pulse(input logic f);
    if (f) fifo_access <= 1'b1;
    else fault_clear <= 1'b1;
    tick(1);
    fifo_access <= 1'b0;
    fault_clear <= 1'b0;
    tick(2);
  endtask
  task automatic feed(input logic [15:0] d, input int n);
    repeat (n) begin
      sample.valid   <= 1'b1;
      sample.meas[0] <= BASE + d;
      tick(1);
      sample.valid <= 1'b0;
      tick(2);
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_regs();
    rd_chk(THRESHOLD_FIRST_OFFSET, THRESHOLD_RESET);
    rd_chk(THRESHOLD_LAST_OFFSET, THRESHOLD_RESET);
    rd_chk(STUCK_TIMEOUT_OFFSET, STUCK_TIMEOUT_RESET);
    wr_rd(8'h05, 8'h15, 8'h15);
    wr_rd(8'h06, 8'h80, THRESHOLD_MAX);
    wr_rd(STUCK_TIMEOUT_OFFSET, 8'hFF, 8'hFF);
    wr_rd(8'h20, 8'h33, UNMAPPED_READ);
    wr_rd(STUCK_TIMEOUT_OFFSET, 8'h00, 8'h00);
  endtask
  task automatic test_calib();
    feed(16'h0000, 1);
    `CHK(touch_status, 8'h00)
    feed(16'h0040, 1);
    `CHK(touch_status, 8'h01)
    feed(16'h003F, 1);
    `CHK(touch_status[0], 1'b0)
    feed(16'h0020, 70);
    feed(16'h0050, 1);
    `CHK(touch_status[0], 1'b1)
    cfg.auto_calib_enable <= 1'b1;
    feed(16'h0050, 140);
    `CHK(touch_status[0], 1'b1)
    feed(16'h0020, 70);
    feed(16'h0050, 1);
    `CHK(touch_status[0], 1'b0)
    cfg.auto_calib_enable <= 1'b0;
    acc(1'b1, STUCK_TIMEOUT_OFFSET, 8'h01);
    feed(16'h0070, 1);
    `CHK(touch_status[0], 1'b1)
    feed(16'h0070, 130);
    `CHK(touch_status[0], 1'b0)
  endtask
  task automatic spacing(input int hold);
    int t0;
    tick(300);
    buffer_empty_flag <= 1'b0;
    t0 = cyc;
    wait_alert(3);
    `CHK(cyc - t0 <= 2, 1'b1)
    t0 = cyc;
    pulse(1'b1);
    `CHK(alert_oe, 1'b0)
    tick(4);
    `CHK(alert_oe, 1'b0)
    buffer_empty_flag <= 1'b1;
    tick(2);
    buffer_empty_flag <= 1'b0;
    wait_alert(hold + 10);
    `CHK(cyc - t0 >= hold && cyc - t0 <= hold + 3, 1'b1)
    pulse(1'b1);
    buffer_empty_flag <= 1'b1;
    tick(2);
  endtask
  task automatic test_fault();
    tick(300);
    fault_code <= FAULT_SHORT_GROUND;
    wait_alert(3);
    pulse(1'b0);
    `CHK(alert_oe, 1'b1)
    cfg.stop_mode <= 1'b1;
    pulse(1'b0);
    `CHK(alert_oe, 1'b0)
    fault_code    <= FAULT_NONE;
    cfg.stop_mode <= 1'b0;
    tick(30);
    fault_code <= FAULT_SHORT_SUPPLY;
    wait_alert(3);
    cfg.stop_mode <= 1'b1;
    pulse(1'b0);
    `CHK(alert_oe, 1'b0)
    fault_code    <= FAULT_NONE;
    cfg.stop_mode <= 1'b0;
  endtask
  task automatic test_disabled();
    cfg.alert_enable <= 1'b0;
    tick(30);
    buffer_empty_flag <= 1'b0;
    fault_code        <= FAULT_SHORT_GROUND;
    tick(30);
    `CHK(alert_oe, 1'b0)
    buffer_empty_flag <= 1'b1;
    fault_code        <= FAULT_NONE;
    cfg.alert_enable  <= 1'b1;
    tick(5);
    `CHK(alert_oe, 1'b0)
  endtask
  initial begin
    rst               = 1'b1;
    cyc               = 0;
    n_fail            = 0;
    n_tests           = 0;
    cfg               = '{1'b1, 8'h01, 8'h01, 8'h03, 1'b0, 1'b0, 1'b0};
    buffer_empty_flag = 1'b1;
    fault_code        = FAULT_NONE;
    fifo_access       = 1'b0;
    fault_clear       = 1'b0;
    sample            = '{1'b0, {ELECTRODES{BASE}}};
    tick(20);
    rst <= 1'b0;
    tick(2);
    test_regs();
    test_calib();
    spacing(HOLD);
    cfg.low_power_run <= 1'b1;
    spacing(HOLD_LP);
    cfg.low_power_run <= 1'b0;
    test_fault();
    test_disabled();
    finish_test();
  end
endmodule
